/* File: src/mpfi_consts.svh */
// Constants for the motor program flow interpreter
`ifndef MPFI_CONSTS_SVH
`define MPFI_CONSTS_SVH
`define MPFI_STACK_DEPTH   32
`define MPFI_USER_REGS     510
`define MPFI_ANALOG_CNT    6
`define MPFI_DIV_MAX       16'h7FFF
`define MPFI_LEVEL_MAX     9'h0FF
`define MPFI_LOOP_MAX      9'h0FF
`define MPFI_FIRST_LINE    10'h001
`define MPFI_MV_PER_COUNT  20
`define MPFI_MV_FULL_SCALE 5100
// Literal, user and predefined register selectors
`define MPFI_SEL_LIT       4'h0
`define MPFI_SEL_USER      4'h1
`define MPFI_SEL_IND       4'h2
`define MPFI_SEL_RAMP      4'h3
`define MPFI_SEL_START     4'h4
`define MPFI_SEL_TOP       4'h5
`define MPFI_SEL_DELAY     4'h6
`define MPFI_SEL_LOOP      4'h7
`define MPFI_SEL_POS       4'h8
`define MPFI_SEL_ANALOG    4'h9
`endif

/* File: src/mpfi_pkg.sv */
// Types for the motor program flow interpreter
package mpfi_pkg;
   typedef enum logic [3:0]
   {
      OP_NOP      = 4'h0,
      OP_AJUMP_GE = 4'h1,
      OP_AJUMP_LT = 4'h2,
      OP_CALL     = 4'h3,
      OP_EXIT     = 4'h4,
      OP_LOOP_BEG = 4'h5,
      OP_LOOP_END = 4'h6,
      OP_ASSIGN   = 4'h7,
      OP_STORE    = 4'h8,
      OP_LOAD     = 4'h9
   } mpfi_op_t;

   typedef enum logic [1:0]
   {
      AR_ADD = 2'h0,
      AR_SUB = 2'h1,
      AR_MUL = 2'h2,
      AR_DIV = 2'h3
   } mpfi_arith_t;

   typedef enum logic [1:0]
   {
      ST_IDLE  = 2'h0,
      ST_READ  = 2'h1,
      ST_EXEC  = 2'h2,
      ST_HALT  = 2'h3
   } mpfi_state_t;

   typedef struct packed
   {
      mpfi_state_t  state;
      logic [9:0]   line;
      logic [5:0]   sp;
      logic [1:0]   ph;
      logic [9:0]   loop_start;
      logic         loop_open;
      logic [7:0]   loop_cnt;
      logic         loop_active;
      logic [15:0]  ramp;
      logic [15:0]  start_rate;
      logic [15:0]  top_rate;
      logic [15:0]  delay;
      logic [15:0]  opa;
      logic [15:0]  opb;
      logic         done;
      logic         err;
      logic         halted;
   } mpfi_state_s_t;
endpackage

/* File: src/mpfi_ram.sv */
// Single-port storage with registered read data
`timescale 1ns/1ps
`default_nettype none
module mpfi_ram
(
   // Clock
   input  wire logic        clock,
   // Access
   input  wire logic        we,
   input  wire logic [8:0]  addr,
   input  wire logic [15:0] wdata,
   output logic      [15:0] rdata
);
   logic [15:0] mem [0:511];

   always_ff @(posedge clock)
   begin
      if (we)
      begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule
`default_nettype wire

/* File: src/mpfi_core.sv */
// Program flow and register arithmetic interpreter core
`timescale 1ns/1ps
`default_nettype none
`include "mpfi_consts.svh"

// Contract
// (RULE1) Greater jump branches when level >= reference
// (RULE2) Less jump branches only when level below
// (RULE3) Reference level 0..255, one of six inputs
// (RULE4) Level code compared directly, 0.02 V/count
// (RULE5) Six analogue registers hold 0..255 codes
// (RULE6) Call pushes next line, then jumps
// (RULE7) Exit pops return line and resumes
// (RULE8) Return stack thirty-two levels deep
// (RULE9) Loop close count 1..255 in loop counter
// (RULE10) Segment repeated N times, then continue
// (RULE11) No opening marker repeats from line 1
// (RULE12) 510 user registers, indexes 1..510
// (RULE13) Seven predefined dedicated registers
// (RULE14) Position counter readable as operand
// (RULE15) Register contents may select user register
// (RULE16) At most three registers per assignment
// (RULE17) Add, subtract, multiply, divide only
// (RULE18) Values unsigned within 0..65535
// (RULE19) Division operand above 32767 is error
// (RULE20) Quotient truncated toward zero
// (RULE21) User registers copy out and restore
// (RULE22) Call on full stack errors and halts
// (RULE23) Out-of-range result errors, keeps destination
module mpfi_core
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Instruction issue
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic [3:0]  cmd_op,
   input  wire logic [9:0]  cmd_target,
   input  wire logic [7:0]  cmd_count,
   input  wire logic [2:0]  cmd_analog,
   input  wire logic [7:0]  cmd_level,
   input  wire logic [1:0]  cmd_arith,
   input  wire logic [3:0]  cmd_dst_sel,
   input  wire logic [9:0]  cmd_dst_idx,
   input  wire logic [3:0]  cmd_a_sel,
   input  wire logic [15:0] cmd_a_val,
   input  wire logic [3:0]  cmd_b_sel,
   input  wire logic [15:0] cmd_b_val,
   input  wire logic [1:0]  cmd_nregs,
   // Motion engine and converter
   input  wire logic [15:0] position,
   input  wire logic [47:0] analog_level_regs,
   // Program state
   output logic      [9:0]  line,
   output logic             done,
   output logic             err,
   output logic             halted,
   output logic      [15:0] ramp,
   output logic      [15:0] start_rate,
   output logic      [15:0] top_rate,
   output logic      [15:0] delay,
   output logic      [7:0]  loop_counter,
   // Nonvolatile copy port
   input  wire logic        nv_we,
   input  wire logic [8:0]  nv_addr,
   input  wire logic [15:0] nv_wdata,
   output logic      [15:0] nv_rdata
);
   mpfi_pkg::mpfi_state_s_t s_r;
   mpfi_pkg::mpfi_state_s_t s_nxt;

   logic [9:0]  stack_r [0:`MPFI_STACK_DEPTH-1];
   logic        push;
   logic [7:0]  level_sel;
   logic [16:0] sum;
   logic [16:0] diff;
   logic [31:0] prod;
   logic [15:0] quot;
   logic [15:0] result;
   logic        res_bad;
   logic        ram_we;
   logic [8:0]  ram_addr;
   logic [15:0] ram_wdata;
   logic [15:0] ram_rdata;
   logic [15:0] ind_idx;

   // Index 1..N maps to storage word 0..N-1
   function automatic logic [8:0] user_addr(input logic [15:0] idx);
      logic [15:0] t;
      t = idx - 16'h0001;
      return t[8:0];
   endfunction

   function automatic logic user_ok(input logic [15:0] idx);
      return (idx != 16'h0000) && (idx <= 16'(`MPFI_USER_REGS));
   endfunction

   // Operand fetch from literal, user or predefined registers
   function automatic logic [15:0] pick(input logic [3:0] sel,
                                        input logic [15:0] val,
                                        input logic [15:0] ramv,
                                        input mpfi_pkg::mpfi_state_s_t st,
                                        input logic [15:0] pos,
                                        input logic [7:0] lvl);
      logic [15:0] r;
      r = val;
      unique case (sel)
         `MPFI_SEL_USER, `MPFI_SEL_IND: r = ramv;
         `MPFI_SEL_RAMP:   r = st.ramp;
         `MPFI_SEL_START:  r = st.start_rate;
         `MPFI_SEL_TOP:    r = st.top_rate;
         `MPFI_SEL_DELAY:  r = st.delay;
         `MPFI_SEL_LOOP:   r = {8'h00, st.loop_cnt};
         // (RULE14) position as operand
         `MPFI_SEL_POS:    r = pos;
         `MPFI_SEL_ANALOG: r = {8'h00, lvl};
         default:          r = val;
      endcase
      return r;
   endfunction

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // (RULE12) user register array
   mpfi_ram u_ram
   (
      .clock (clock),
      .we    (ram_we),
      .addr  (ram_addr),
      .wdata (ram_wdata),
      .rdata (ram_rdata)
   );

   // (RULE5) select one analogue code
   always_comb
   begin
      level_sel = analog_level_regs[8*cmd_analog +: 8];
   end

   // (RULE17) four operators
   always_comb
   begin
      sum  = {1'b0, s_r.opa} + {1'b0, s_r.opb};
      diff = {1'b0, s_r.opa} - {1'b0, s_r.opb};
      prod = s_r.opa * s_r.opb;
      // (RULE20) integer divide truncates
      quot = (s_r.opb == 16'h0000) ? 16'h0000 : s_r.opa / s_r.opb;
      result  = s_r.opa;
      res_bad = 1'b0;
      unique case (mpfi_pkg::mpfi_arith_t'(cmd_arith))
         mpfi_pkg::AR_ADD:
         begin
            result = sum[15:0];
            res_bad = sum[16];
         end
         mpfi_pkg::AR_SUB:
         begin
            result = diff[15:0];
            res_bad = diff[16];
         end
         mpfi_pkg::AR_MUL:
         begin
            result = prod[15:0];
            res_bad = (prod[31:16] != 16'h0000);
         end
         mpfi_pkg::AR_DIV:
         begin
            result = quot;
            // (RULE19) division operand limit
            res_bad = (s_r.opa > `MPFI_DIV_MAX) ||
                      (s_r.opb > `MPFI_DIV_MAX) ||
                      (s_r.opb == 16'h0000);
         end
      endcase
   end

   assign cmd_ready = (s_r.state == mpfi_pkg::ST_IDLE);
   assign ind_idx   = (cmd_dst_sel == `MPFI_SEL_IND) ? ram_rdata
                                                     : {6'h00, cmd_dst_idx};

   // ------------------------------------------------------------
   // Sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      s_nxt     = s_r;
      s_nxt.done = 1'b0;
      push      = 1'b0;
      ram_we    = nv_we;
      ram_addr  = nv_addr;
      ram_wdata = nv_wdata;
      unique case (s_r.state)
         mpfi_pkg::ST_IDLE:
         begin
            if (cmd_valid)
            begin
               s_nxt.done = 1'b1;
               s_nxt.line = s_r.line + 10'h001;
               unique case (mpfi_pkg::mpfi_op_t'(cmd_op))
                  mpfi_pkg::OP_AJUMP_GE:
                  begin
                     // (RULE1) greater-or-equal branch
                     // (RULE3) eight-bit reference
                     // (RULE4) direct code compare
                     if (level_sel >= cmd_level)
                     begin
                        s_nxt.line = cmd_target;
                     end
                  end
                  mpfi_pkg::OP_AJUMP_LT:
                  begin
                     // (RULE2) strictly-below branch
                     if (level_sel < cmd_level)
                     begin
                        s_nxt.line = cmd_target;
                     end
                  end
                  mpfi_pkg::OP_CALL:
                  begin
                     // (RULE22) full stack halts
                     if (s_r.sp == 6'(`MPFI_STACK_DEPTH))
                     begin
                        s_nxt.err = 1'b1;
                        s_nxt.halted = 1'b1;
                        s_nxt.state = mpfi_pkg::ST_HALT;
                     end
                     else
                     begin
                        // (RULE6) push then jump
                        push = 1'b1;
                        // (RULE8) thirty-two return lines
                        s_nxt.sp = s_r.sp + 6'h01;
                        s_nxt.line = cmd_target;
                     end
                  end
                  mpfi_pkg::OP_EXIT:
                  begin
                     // (RULE7) pop return line
                     if (s_r.sp != 6'h00)
                     begin
                        s_nxt.sp = s_r.sp - 6'h01;
                        s_nxt.err = 1'b0;
                        s_nxt.line = stack_r[s_nxt.sp[4:0]];
                     end
                     else
                     begin
                        s_nxt.err = 1'b1;
                     end
                  end
                  mpfi_pkg::OP_LOOP_BEG:
                  begin
                     s_nxt.loop_start  = s_r.line + 10'h001;
                     s_nxt.loop_open   = 1'b1;
                     s_nxt.loop_active = 1'b0;
                  end
                  mpfi_pkg::OP_LOOP_END:
                  begin
                     // (RULE9) count 1..255 in loop counter
                     // (RULE10) repeat N passes
                     if (!s_r.loop_active)
                     begin
                        s_nxt.loop_cnt = cmd_count;
                        s_nxt.loop_active = (cmd_count > 8'h01);
                        if (cmd_count > 8'h01)
                        begin
                           s_nxt.loop_cnt = cmd_count - 8'h01;
                           // (RULE11) no opening marker
                           s_nxt.line = s_r.loop_open ? s_r.loop_start
                                                      : `MPFI_FIRST_LINE;
                        end
                     end
                     else if (s_r.loop_cnt > 8'h01)
                     begin
                        s_nxt.loop_cnt = s_r.loop_cnt - 8'h01;
                        s_nxt.line = s_r.loop_open ? s_r.loop_start
                                                   : `MPFI_FIRST_LINE;
                     end
                     else
                     begin
                        s_nxt.loop_cnt = 8'h00;
                        s_nxt.loop_active = 1'b0;
                        s_nxt.loop_open = 1'b0;
                     end
                  end
                  mpfi_pkg::OP_ASSIGN:
                  begin
                     // (RULE16) three registers at most
                     if (cmd_nregs == 2'h3 && cmd_a_sel != `MPFI_SEL_LIT
                         && cmd_b_sel != `MPFI_SEL_LIT
                         && cmd_dst_sel == `MPFI_SEL_IND)
                     begin
                        s_nxt.err = 1'b1;
                     end
                     else
                     begin
                        s_nxt.done = 1'b0;
                        s_nxt.line = s_r.line;
                        s_nxt.state = mpfi_pkg::ST_READ;
                        s_nxt.opa = cmd_a_val;
                        s_nxt.opb = cmd_b_val;
                        ram_addr = user_addr(cmd_a_val);
                        ram_we = 1'b0;
                     end
                  end
                  default:
                  begin
                  end
               endcase
            end
         end
         mpfi_pkg::ST_READ:
         begin
            // (RULE15) pointer read, then indirect operand
            // Only the second operand and the destination go indirect
            ram_we = 1'b0;
            s_nxt.ph = s_r.ph + 2'h1;
            unique case (s_r.ph)
               2'h0:
               begin
                  s_nxt.opa = pick(cmd_a_sel, cmd_a_val, ram_rdata, s_r,
                                   position, level_sel);
                  ram_addr = user_addr(cmd_b_val);
               end
               2'h1:
               begin
                  s_nxt.opb = pick(cmd_b_sel, cmd_b_val, ram_rdata, s_r,
                                   position, level_sel);
                  ram_addr = user_addr(ram_rdata);
               end
               default:
               begin
                  if (cmd_b_sel == `MPFI_SEL_IND)
                  begin
                     s_nxt.opb = ram_rdata;
                  end
                  ram_addr = user_addr({6'h00, cmd_dst_idx});
                  s_nxt.ph = 2'h0;
                  s_nxt.state = mpfi_pkg::ST_EXEC;
               end
            endcase
         end
         mpfi_pkg::ST_EXEC:
         begin
            s_nxt.state = mpfi_pkg::ST_IDLE;
            s_nxt.done = 1'b1;
            s_nxt.line = s_r.line + 10'h001;
            // (RULE23) bad result keeps destination
            // (RULE18) sixteen-bit unsigned range
            if (res_bad)
            begin
               s_nxt.err = 1'b1;
            end
            else
            begin
               // (RULE13) dedicated predefined registers
               unique case (cmd_dst_sel)
                  `MPFI_SEL_RAMP:  s_nxt.ramp = result;
                  `MPFI_SEL_START: s_nxt.start_rate = result;
                  `MPFI_SEL_TOP:   s_nxt.top_rate = result;
                  `MPFI_SEL_DELAY: s_nxt.delay = result;
                  `MPFI_SEL_LOOP:  s_nxt.loop_cnt = result[7:0];
                  default:
                  begin
                     if (user_ok(ind_idx))
                     begin
                        ram_we = 1'b1;
                        ram_addr = user_addr(ind_idx);
                        ram_wdata = result;
                     end
                  end
               endcase
            end
         end
         mpfi_pkg::ST_HALT:
         begin
            s_nxt.halted = 1'b1;
            s_nxt.err = 1'b1;
         end
      endcase
   end

   // (RULE6) return line stored on the same edge as the jump
   always_ff @(posedge clock)
   begin
      if (push)
      begin
         stack_r[s_r.sp[4:0]] <= s_r.line + 10'h001;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // (RULE21) nonvolatile copy read path
   assign nv_rdata     = ram_rdata;
   assign line         = s_r.line;
   assign done         = s_r.done;
   assign err          = s_r.err;
   assign halted       = s_r.halted;
   assign ramp         = s_r.ramp;
   assign start_rate   = s_r.start_rate;
   assign top_rate     = s_r.top_rate;
   assign delay        = s_r.delay;
   assign loop_counter = s_r.loop_cnt;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_ge_jump;
      cmd_ready && cmd_valid && cmd_op == 4'h1 && level_sel >= cmd_level;
   endsequence

   a_ge_jump_taken: assert property (@(posedge clock) disable iff (rst) // (RULE1)
      s_ge_jump |=> line == $past(cmd_target))
      else $error("greater jump not taken");
   a_lt_jump_skip: assert property (@(posedge clock) disable iff (rst) // (RULE2)
      (cmd_ready && cmd_valid && cmd_op == 4'h2 && level_sel >= cmd_level)
      |=> line == $past(line) + 10'h001)
      else $error("less jump taken wrongly");
   a_call_target: assert property (@(posedge clock) disable iff (rst) // (RULE6)
      (push && s_r.state == mpfi_pkg::ST_IDLE) |=> line == $past(cmd_target))
      else $error("call target wrong");
   a_call_depth: assert property (@(posedge clock) disable iff (rst) // (RULE8)
      push |=> s_r.sp == $past(s_r.sp) + 5'h01)
      else $error("stack pointer not advanced");
   a_halt_stays: assert property (@(posedge clock) disable iff (rst) // (RULE22)
      s_r.state == mpfi_pkg::ST_HALT |=> halted && err)
      else $error("halt not flagged");
   a_bad_result: assert property (@(posedge clock) disable iff (rst) // (RULE23)
      (s_r.state == mpfi_pkg::ST_EXEC && res_bad) |=> err)
      else $error("bad result not flagged");
   a_div_limit: assert property (@(posedge clock) disable iff (rst) // (RULE19)
      (cmd_arith == 2'h3 && s_r.opa > 16'h7FFF) |-> res_bad)
      else $error("division limit missed");
   a_loop_count: assert property (@(posedge clock) disable iff (rst) // (RULE10)
      (cmd_ready && cmd_valid && cmd_op == 4'h6 && !s_r.loop_active
       && cmd_count > 8'h01) |=> loop_counter == $past(cmd_count) - 8'h01)
      else $error("loop count wrong");
endmodule
`default_nettype wire

/* File: testbench/mpfi_motion_model.sv */
// Behavioural motion engine and analogue converter beside the core
`timescale 1ns/1ps
`default_nettype none
module mpfi_motion_model
(
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Bench control
   input  wire logic        step,
   input  wire logic        lvl_we,
   input  wire logic [2:0]  lvl_idx,
   input  wire logic [7:0]  lvl_val,
   // Core side
   output logic      [15:0] position,
   output logic      [47:0] analog_level_regs
);
   always_ff @(posedge clock)
   begin
      if (rst)
         position <= 16'h0000;
      else if (step)
         position <= position + 16'h0001;
   end

   always_ff @(posedge clock)
   begin
      if (rst)
         analog_level_regs <= 48'h000000000000;
      else if (lvl_we)
         analog_level_regs[8 * lvl_idx +: 8] <= lvl_val;
   end
endmodule
`default_nettype wire

/* File: testbench/motor_program_flow_interp_tb.sv */
// Self-checking bench for the program flow interpreter core
`timescale 1ns/1ps
`default_nettype none
`include "mpfi_consts.svh"
module motor_program_flow_interp_tb;
   typedef struct packed
      {logic [2:0] m; logic [9:0] l; logic [15:0] t; logic e;} mpfi_exp_t;
   logic        clock = 1'b0;
   logic        rst, cmd_valid, cmd_ready, step, lvl_we, done, err, halted;
   logic [3:0]  cmd_op, cmd_dst_sel, cmd_a_sel, cmd_b_sel;
   logic [9:0]  cmd_target, cmd_dst_idx, line, exp_line, ls;
   logic [7:0]  cmd_count, cmd_level, lvl_val, lv, rf;
   logic [2:0]  cmd_analog, lvl_idx;
   logic [1:0]  cmd_arith, cmd_nregs;
   logic [15:0] cmd_a_val, cmd_b_val, position, top_rate, a, b, w;
   logic [47:0] analog_level_regs;
   logic [15:0] ea[6] = '{16'hFFFF, 16'h0001, 16'h012C, 16'h8000,
                          16'h0004, 16'h0004};
   logic [15:0] eb[6] = '{16'h0001, 16'h0002, 16'h012C, 16'h0002,
                          16'h8000, 16'h0000};
   int          cnts[3] = '{1, 4, 255};
   int          errors = 0;
   int          checks = 0;
   int          seed = 31;
   mpfi_exp_t   expq[$];
   mpfi_exp_t   cur;
   logic [9:0]  stk[$];

   always #5 clock = ~clock;

   mpfi_core mpfi_core_inst
   (
      .clock(clock), .rst(rst), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_target(cmd_target),
      .cmd_count(cmd_count), .cmd_analog(cmd_analog), .cmd_level(cmd_level),
      .cmd_arith(cmd_arith), .cmd_dst_sel(cmd_dst_sel),
      .cmd_dst_idx(cmd_dst_idx), .cmd_a_sel(cmd_a_sel),
      .cmd_a_val(cmd_a_val), .cmd_b_sel(cmd_b_sel), .cmd_b_val(cmd_b_val),
      .cmd_nregs(cmd_nregs), .position(position),
      .analog_level_regs(analog_level_regs), .line(line), .done(done),
      .err(err), .halted(halted), .ramp(), .start_rate(),
      .top_rate(top_rate), .delay(), .loop_counter(), .nv_we(1'b0),
      .nv_addr(9'h000), .nv_wdata(16'h0000), .nv_rdata()
   );

   mpfi_motion_model mpfi_motion_model_inst
   (
      .clock(clock), .rst(rst), .step(step), .lvl_we(lvl_we),
      .lvl_idx(lvl_idx), .lvl_val(lvl_val), .position(position),
      .analog_level_regs(analog_level_regs)
   );

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(string name, logic [15:0] seen, logic [15:0] want);
      checks++;
      if (seen !== want)
      begin
         errors++;
         $display("[ERR] %s expected %0h seen %0h", name, want, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic do_reset(int n);
      rst = 1'b1;
      repeat (n) @(negedge clock);
      rst = 1'b0;
      exp_line = 10'h000;
   endtask

   task automatic note(logic [2:0] m, logic [15:0] t, logic e);
      expq.push_back(mpfi_exp_t'({m, exp_line, t, e}));
   endtask

   // Assign keeps cmd_valid up until done; flow ops drop it after one edge
   task automatic send(logic [3:0] op, logic [9:0] tgt, logic [7:0] cnt,
                       logic [2:0] ana, logic [7:0] lvl);
      int n;
      n = 0;
      cmd_op = op;
      cmd_target = tgt;
      cmd_count = cnt;
      cmd_analog = ana;
      cmd_level = lvl;
      cmd_valid = 1'b1;
      @(negedge clock);
      if (op != mpfi_pkg::OP_ASSIGN)
         cmd_valid = 1'b0;
      while (done !== 1'b1 && n < 10)
      begin
         @(negedge clock);
         n++;
      end
      cmd_valid = 1'b0;
      @(negedge clock);
   endtask

   task automatic asg(logic [1:0] ar, logic [3:0] ds, logic [9:0] di,
                      logic [3:0] sa, logic [15:0] av, logic [3:0] sb,
                      logic [15:0] bv, logic [2:0] m, logic [15:0] t,
                      logic e);
      cmd_arith = ar;
      cmd_dst_sel = ds;
      cmd_dst_idx = di;
      cmd_a_sel = sa;
      cmd_a_val = av;
      cmd_b_sel = sb;
      cmd_b_val = bv;
      cmd_nregs = 2'(1 + int'(sa != 4'h0) + int'(sb != 4'h0));
      exp_line = exp_line + 10'h001;
      note(m, t, e);
      send(mpfi_pkg::OP_ASSIGN, 10'h000, 8'h00, 3'h0, 8'h00);
   endtask

   task automatic top_lit(logic [1:0] ar, logic [15:0] av, logic [15:0] bv,
                          logic [2:0] m, logic [15:0] t, logic e);
      asg(ar, `MPFI_SEL_TOP, 10'h000, `MPFI_SEL_LIT, av, `MPFI_SEL_LIT, bv,
          m, t, e);
   endtask

   task automatic nest(int n);
      for (int i = 0; i < n; i++)
      begin
         stk.push_back(exp_line + 10'h001);
         exp_line = 10'(200 + 3 * i);
         note(3'b101, 16'h0000, 1'b0);
         send(mpfi_pkg::OP_CALL, exp_line, 8'h00, 3'h0, 8'h00);
      end
   endtask

   // ----------------------------------------
   // Result watcher
   // ----------------------------------------
   always @(negedge clock)
   begin
      if (done === 1'b1)
      begin
         cur = expq.pop_front();
         if (cur.m[0])
            check("line", 16'(line), 16'(cur.l));
         if (cur.m[1])
            check("top_rate", top_rate, cur.t);
         if (cur.m[2])
            check("err", 16'(err), 16'(cur.e));
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial
   begin
      {cmd_valid, step, lvl_we, cmd_op, cmd_target, cmd_count, cmd_analog,
       cmd_level, cmd_arith, cmd_nregs, cmd_dst_sel, cmd_dst_idx} = '0;
      {cmd_a_sel, cmd_a_val, cmd_b_sel, cmd_b_val, lvl_idx, lvl_val} = '0;
      do_reset(20);
      check("reset_line", 16'(line), 16'h0000);
      for (int i = 0; i < 12; i++)
      begin
         lv = 8'($random(seed));
         rf = (i % 3 == 0) ? lv : 8'($random(seed));
         lvl_idx = 3'(i % 6);
         lvl_val = lv;
         lvl_we = 1'b1;
         @(negedge clock);
         lvl_we = 1'b0;
         exp_line = (i[0] ? (lv < rf) : (lv >= rf)) ? 10'(40 + i)
                    : exp_line + 10'h001;
         note(3'b001, 16'h0000, 1'b0);
         send(i[0] ? 4'h2 : 4'h1, 10'(40 + i), 8'h00, 3'(i % 6), rf);
      end
      nest(32);
      for (int i = 0; i < 32; i++)
      begin
         exp_line = stk.pop_back();
         note(3'b101, 16'h0000, 1'b0);
         send(mpfi_pkg::OP_EXIT, 10'h000, 8'h00, 3'h0, 8'h00);
      end
      nest(32);
      note(3'b100, 16'h0000, 1'b1);
      send(mpfi_pkg::OP_CALL, 10'h3FF, 8'h00, 3'h0, 8'h00);
      note(3'b000, 16'h0000, 1'b1);
      send(mpfi_pkg::OP_CALL, 10'h3FF, 8'h00, 3'h0, 8'h00);
      repeat (4) @(negedge clock);
      check("halted", 16'(halted), 16'h0001);
      expq.delete();
      do_reset(2);
      foreach (cnts[j])
      begin
         top_lit(2'h0, 16'h0000, 16'h0000, 3'b011, 16'h0000, 1'b0);
         exp_line = exp_line + 10'h001;
         note(3'b001, 16'h0000, 1'b0);
         send(mpfi_pkg::OP_LOOP_BEG, 10'h000, 8'h00, 3'h0, 8'h00);
         ls = exp_line;
         for (int k = 1; k <= cnts[j]; k++)
         begin
            asg(2'h0, `MPFI_SEL_TOP, 10'h000, `MPFI_SEL_TOP, 16'h0000,
                `MPFI_SEL_LIT, 16'h0001, 3'b011, 16'(k), 1'b0);
            exp_line = (k < cnts[j]) ? ls : exp_line + 10'h001;
            note(3'b001, 16'h0000, 1'b0);
            send(mpfi_pkg::OP_LOOP_END, 10'h000, 8'(cnts[j]), 3'h0, 8'h00);
         end
      end
      do_reset(2);
      exp_line = `MPFI_FIRST_LINE;
      note(3'b001, 16'h0000, 1'b0);
      send(mpfi_pkg::OP_LOOP_END, 10'h000, 8'h02, 3'h0, 8'h00);
      do_reset(2);
      for (int i = 0; i < 16; i++)
      begin
         a = 16'($random(seed)) & 16'h7FFF;
         b = 16'($random(seed)) & 16'h7FFF;
         if (i % 4 == 1 && a < b)
            {a, b} = {b, a};
         if (i % 4 == 2)
            {a, b} = {a & 16'h00FF, b & 16'h00FF};
         if (i % 4 == 3)
            {a, b} = {(i == 3) ? 16'h7FFF : a, (b & 16'h00FF) | 16'h0001};
         w = (i % 4 == 0) ? a + b : (i % 4 == 1) ? a - b
             : (i % 4 == 2) ? a * b : a / b;
         top_lit(2'(i % 4), a, b, 3'b111, w, 1'b0);
      end
      asg(2'h0, `MPFI_SEL_USER, 10'h001, `MPFI_SEL_LIT, 16'h0064,
          `MPFI_SEL_LIT, 16'h0000, 3'b101, 16'h0000, 1'b0);
      asg(2'h0, `MPFI_SEL_IND, 10'h001, `MPFI_SEL_LIT, 16'h0309,
          `MPFI_SEL_LIT, 16'h0005, 3'b101, 16'h0000, 1'b0);
      asg(2'h0, `MPFI_SEL_TOP, 10'h000, `MPFI_SEL_USER, 16'h0064,
          `MPFI_SEL_IND, 16'h0001, 3'b111, 16'h061C, 1'b0);
      step = 1'b1;
      repeat (7) @(negedge clock);
      step = 1'b0;
      asg(2'h0, `MPFI_SEL_TOP, 10'h000, `MPFI_SEL_POS, 16'h0000,
          `MPFI_SEL_LIT, 16'h0003, 3'b111, 16'h000A, 1'b0);
      for (int i = 0; i < 6; i++)
         top_lit(2'(i < 3 ? i : 3), ea[i], eb[i], 3'b110, 16'h000A, 1'b1);
      do_reset(2);
      asg(2'h0, `MPFI_SEL_IND, 10'h001, `MPFI_SEL_USER, 16'h0001,
          `MPFI_SEL_USER, 16'h0001, 3'b101, 16'h0000, 1'b1);
      repeat (4) @(negedge clock);
      finish_test();
   end

   // Cut a hang short well beyond the expected run length
   initial
   begin
      #1000000;
      errors++;
      finish_test();
   end
endmodule
`default_nettype wire
